// File: rtl/low_gpio_function_mux.sv
// Function multiplexer for the five lowest general purpose pins.
// Assumes the SPI master, stereo source and DSI logic sit elsewhere on
// ref_clk_i; pin inputs are asynchronous and are synchronised here.
`timescale 1ns/1ps

module low_gpio_function_mux (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    // Software configuration: mode and function flattened two bits per pin, output value one bit per pin.
    input wire logic [9:0] io_mode_i,
    input wire logic [9:0] func_sel_i,
    input wire logic [4:0] gpio_out_i,
    // Alternate function sources from core logic.
    input wire logic aux_spi_clock_i,
    input wire logic aux_spi_data_out_i,
    input wire logic aux_spi_select_a_n_i,
    input wire logic aux_spi_select_b_n_i,
    input wire logic shutter_left_i,
    // Pin side.
    input wire logic [4:0] pin_i,
    output logic [4:0] pin_o,
    output logic [4:0] pin_oe_o,
    // Core side results.
    output logic [4:0] gpio_in_o,
    output logic aux_spi_data_in_o,
    output logic [2:0] dsi_lane_count_o,
    output logic strap_done_o
);

    localparam int N = gpio_mux_pkg::PIN_COUNT;

    logic [N-1:0] pin_sync;
    logic [gpio_mux_pkg::STRAP_W-1:0] strap_now;
    logic [gpio_mux_pkg::STRAP_W-1:0] strap_held;
    logic strap_done;
    logic [N-1:0] nxt_pin;
    logic [N-1:0] nxt_oe;

    logic [N-1:0] pin_ff;
    logic [N-1:0] pin_oe_ff;
    logic [N-1:0] gpio_in_ff;
    logic aux_spi_data_in_ff;
    logic [2:0] dsi_lane_count_ff;
    logic strap_done_ff;

    // Lane count from the two strap bits: count is value plus one.
    function automatic logic [2:0] lane_count(
        input logic [gpio_mux_pkg::STRAP_W-1:0] strap
    );
        lane_count = {1'b0, strap} + 3'h1;
    endfunction : lane_count

    // Output value and enable for one pin given its mode and source.
    function automatic logic [1:0] drive(
        input logic [1:0] mode,
        input logic value
    );
        logic [1:0] r;
        r = 2'h0;
        case (mode)
            gpio_mux_pkg::IO_MODE_IN: r = {1'b0, 1'b0};
            gpio_mux_pkg::IO_MODE_OUT: r = {value, 1'b1};
            gpio_mux_pkg::IO_MODE_BIDIR: r = {value, 1'b1};
            gpio_mux_pkg::IO_MODE_OPEN_DRAIN: r = {1'b0, ~value};
            default: r = 2'h0;
        endcase
        drive = r;
    endfunction : drive

    pin_sync #(
        .WIDTH(N)
    ) u_sync (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .async_i(pin_i),
        .sync_o(pin_sync)
    );

    assign strap_now = {pin_sync[gpio_mux_pkg::PIN_SPI_DOUT],
                        pin_sync[gpio_mux_pkg::PIN_SPI_CLK]};

    strap_capture u_strap (
        .ref_clk_i(ref_clk_i),
        .resetn_i(resetn_i),
        .strap_i(strap_now),
        .strap_o(strap_held),
        .done_o(strap_done)
    );

    // Per-pin source selection. Until the strap is taken the strap pins
    // are kept as inputs so the external resistors set their level.
    always_comb begin
        logic [1:0] mode;
        logic [1:0] fsel;
        logic value;
        logic [1:0] d;
        mode = 2'h0;
        fsel = 2'h0;
        value = 1'b0;
        d = 2'h0;
        nxt_pin = '0;
        nxt_oe = '0;
        for (int i = 0; i < N; i++) begin
            mode = io_mode_i[2*i +: 2];
            fsel = func_sel_i[2*i +: 2];
            value = gpio_out_i[i];
            if (fsel == gpio_mux_pkg::FUNC_SPI) begin
                case (i)
                    gpio_mux_pkg::PIN_SPI_CLK: begin
                        value = aux_spi_clock_i;
                        mode = gpio_mux_pkg::IO_MODE_OUT;
                    end
                    gpio_mux_pkg::PIN_SPI_DOUT: begin
                        value = aux_spi_data_out_i;
                        mode = gpio_mux_pkg::IO_MODE_OUT;
                    end
                    gpio_mux_pkg::PIN_SPI_SEL_A: begin
                        value = aux_spi_select_a_n_i;
                        mode = gpio_mux_pkg::IO_MODE_OUT;
                    end
                    gpio_mux_pkg::PIN_ALT4: begin
                        value = aux_spi_select_b_n_i;
                        mode = gpio_mux_pkg::IO_MODE_OUT;
                    end
                    default: begin
                        mode = gpio_mux_pkg::IO_MODE_IN;
                    end
                endcase
            end else if (fsel == gpio_mux_pkg::FUNC_SHUTTER &&
                    i == gpio_mux_pkg::PIN_ALT4) begin
                value = shutter_left_i;
                mode = gpio_mux_pkg::IO_MODE_OUT;
            end
            if (!strap_done && (i == gpio_mux_pkg::PIN_SPI_CLK ||
                    i == gpio_mux_pkg::PIN_SPI_DOUT)) begin
                mode = gpio_mux_pkg::IO_MODE_IN;
            end
            d = drive(mode, value);
            nxt_pin[i] = d[1];
            nxt_oe[i] = d[0];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            pin_ff <= {N{gpio_mux_pkg::GPIO_OUT_RESET}};
            pin_oe_ff <= '0;
        end else begin
            pin_ff <= nxt_pin;
            pin_oe_ff <= nxt_oe;
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            gpio_in_ff <= '0;
            aux_spi_data_in_ff <= 1'b0;
        end else begin
            gpio_in_ff <= pin_sync;
            aux_spi_data_in_ff <= pin_sync[gpio_mux_pkg::PIN_SPI_DIN];
        end
    end

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            dsi_lane_count_ff <= lane_count(gpio_mux_pkg::STRAP_RESET);
            strap_done_ff <= 1'b0;
        end else begin
            dsi_lane_count_ff <= lane_count(strap_held);
            strap_done_ff <= strap_done;
        end
    end

    assign pin_o = pin_ff;
    assign pin_oe_o = pin_oe_ff;
    assign gpio_in_o = gpio_in_ff;
    assign aux_spi_data_in_o = aux_spi_data_in_ff;
    assign dsi_lane_count_o = dsi_lane_count_ff;
    assign strap_done_o = strap_done_ff;

endmodule : low_gpio_function_mux

// File: rtl/gpio_mux_pkg.sv
// Shared constants for the low GPIO pin function multiplexer.
// Assumes a single core clock domain and no register bus.
package gpio_mux_pkg;

    localparam int PIN_COUNT = 5;

    // Pin indices.
    localparam int PIN_SPI_DIN = 0;
    localparam int PIN_SPI_CLK = 1;
    localparam int PIN_SPI_DOUT = 2;
    localparam int PIN_SPI_SEL_A = 3;
    localparam int PIN_ALT4 = 4;

    // Per-pin I/O mode encoding.
    localparam logic [1:0] IO_MODE_IN = 2'h0;
    localparam logic [1:0] IO_MODE_OUT = 2'h1;
    localparam logic [1:0] IO_MODE_BIDIR = 2'h2;
    localparam logic [1:0] IO_MODE_OPEN_DRAIN = 2'h3;

    // Per-pin function select encoding.
    localparam logic [1:0] FUNC_GPIO = 2'h0;
    localparam logic [1:0] FUNC_SPI = 2'h1;
    localparam logic [1:0] FUNC_SHUTTER = 2'h2;

    // Reset values: pins reset undriven with output value zero; IO_MODE_RESET is unused.
    localparam logic [1:0] IO_MODE_RESET = IO_MODE_OUT;
    localparam logic [1:0] FUNC_RESET = FUNC_GPIO;
    localparam logic GPIO_OUT_RESET = 1'b0;

    // Strap field and boot sampling.
    localparam int STRAP_W = 2;
    localparam int STRAP_HI_BIT = 1;
    localparam int STRAP_LO_BIT = 0;
    localparam logic [STRAP_W-1:0] STRAP_RESET = 2'h0;
    localparam int LANE_W = 3;
    localparam int SYNC_STAGES = 2;
    // Cycles after reset release before the strap is taken, so the
    // synchronised pin levels are settled.
    localparam int STRAP_SETTLE_CYCLES = SYNC_STAGES + 1;

endpackage : gpio_mux_pkg

// File: rtl/pin_sync.sv
// Two-flop synchroniser for a vector of pin inputs.
// Assumes inputs are asynchronous to ref_clk_i.
`timescale 1ns/1ps
module pin_sync #(
    parameter int WIDTH = 5
) (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [WIDTH-1:0] async_i,
    output logic [WIDTH-1:0] sync_o
);

    logic [WIDTH-1:0] meta_ff;
    logic [WIDTH-1:0] sync_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            meta_ff <= '0;
            sync_ff <= '0;
        end else begin
            meta_ff <= async_i;
            sync_ff <= meta_ff;
        end
    end

    assign sync_o = sync_ff;

endmodule : pin_sync

// File: rtl/strap_capture.sv
// Captures the lane-count strap once after reset release.
// Assumes the strap bits arrive already synchronised.
`timescale 1ns/1ps
module strap_capture (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [gpio_mux_pkg::STRAP_W-1:0] strap_i,
    output logic [gpio_mux_pkg::STRAP_W-1:0] strap_o,
    output logic done_o
);

    logic [1:0] settle_ff;
    logic [gpio_mux_pkg::STRAP_W-1:0] strap_ff;
    logic done_ff;

    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            settle_ff <= 2'h0;
        end else if (!done_ff) begin
            settle_ff <= settle_ff + 2'h1;
        end
    end

    // The strap is taken exactly once and then frozen until reset.
    always_ff @(posedge ref_clk_i) begin
        if (!resetn_i) begin
            strap_ff <= gpio_mux_pkg::STRAP_RESET;
            done_ff <= 1'b0;
        end else if (!done_ff && (32'(settle_ff) ==
                gpio_mux_pkg::STRAP_SETTLE_CYCLES - 1)) begin
            strap_ff <= strap_i;
            done_ff <= 1'b1;
        end
    end

    assign strap_o = strap_ff;
    assign done_o = done_ff;

endmodule : strap_capture

// File: verification/gpio_mux_checker.sv
// Port assertions for the low pin function multiplexer.
// Assumes one clock and a synchronous active-low reset.
`timescale 1ns/1ps
module gpio_mux_checker (
    input wire logic ref_clk_i,
    input wire logic resetn_i,
    input wire logic [9:0] io_mode_i,
    input wire logic [9:0] func_sel_i,
    input wire logic [4:0] gpio_out_i,
    input wire logic aux_spi_clock_i,
    input wire logic aux_spi_data_out_i,
    input wire logic aux_spi_select_a_n_i,
    input wire logic aux_spi_select_b_n_i,
    input wire logic shutter_left_i,
    input wire logic [4:0] pin_i,
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oe_o,
    input wire logic aux_spi_data_in_o,
    input wire logic [2:0] dsi_lane_count_o,
    input wire logic strap_done_o
);
    localparam logic [3:0] SPI_OUT = {gpio_mux_pkg::FUNC_SPI, 2'h1};
    localparam logic [3:0] SH_OUT = {gpio_mux_pkg::FUNC_SHUTTER, 2'h1};
    localparam logic [3:0] IO_OUT = {gpio_mux_pkg::FUNC_GPIO, 2'h1};
    localparam logic [3:0] IO_OD = {gpio_mux_pkg::FUNC_GPIO, 2'h3};
    default clocking dc @(posedge ref_clk_i); endclocking
    default disable iff (!resetn_i);
    property p_shutter;
        $past(resetn_i) && $past({func_sel_i[9:8], io_mode_i[9:8]}) == SH_OUT
            |-> pin_oe_o[4] && pin_o[4] == $past(shutter_left_i);
    endproperty
    a_shutter: assert property (p_shutter) else $error("shutter wrong");
    property p_sel_b;
        $past(resetn_i) && $past({func_sel_i[9:8], io_mode_i[9:8]}) == SPI_OUT
            |-> pin_oe_o[4] && pin_o[4] == $past(aux_spi_select_b_n_i);
    endproperty
    a_sel_b: assert property (p_sel_b) else $error("select b wrong");
    property p_sel_a;
        $past(resetn_i) && $past({func_sel_i[7:6], io_mode_i[7:6]}) == SPI_OUT
            |-> pin_oe_o[3] && pin_o[3] == $past(aux_spi_select_a_n_i);
    endproperty
    a_sel_a: assert property (p_sel_a) else $error("select a wrong");
    property p_dout;
        $past(strap_done_o) && $past({func_sel_i[5:4], io_mode_i[5:4]}) == SPI_OUT
            |-> pin_oe_o[2] && pin_o[2] == $past(aux_spi_data_out_i);
    endproperty
    a_dout: assert property (p_dout) else $error("data out wrong");
    property p_clk;
        $past(strap_done_o) && $past({func_sel_i[3:2], io_mode_i[3:2]}) == SPI_OUT
            |-> pin_oe_o[1] && pin_o[1] == $past(aux_spi_clock_i);
    endproperty
    a_clk: assert property (p_clk) else $error("clock out wrong");
    property p_din;
        $stable(pin_i[0]) [*4] |-> aux_spi_data_in_o == pin_i[0];
    endproperty
    a_din: assert property (p_din) else $error("data in wrong");
    property p_od;
        $past(resetn_i) && $past({func_sel_i[9:8], io_mode_i[9:8]}) == IO_OD
            |-> !pin_o[4] && pin_oe_o[4] == !$past(gpio_out_i[4]);
    endproperty
    a_od: assert property (p_od) else $error("open drain wrong");
    property p_gpio;
        $past(resetn_i) && $past({func_sel_i[7:6], io_mode_i[7:6]}) == IO_OUT
            |-> pin_oe_o[3] && pin_o[3] == $past(gpio_out_i[3]);
    endproperty
    a_gpio: assert property (p_gpio) else $error("gpio out wrong");
    property p_boot;
        $rose(resetn_i) |-> !strap_done_o ##[1:6] strap_done_o;
    endproperty
    a_boot: assert property (p_boot) else $error("strap late");
    property p_hold;
        strap_done_o |=> strap_done_o && $stable(dsi_lane_count_o);
    endproperty
    a_hold: assert property (p_hold) else $error("lanes moved");
    c_boot: cover property ($rose(strap_done_o));
    c_clk: cover property ($rose(pin_o[1]) && pin_oe_o[1]);
    c_od: cover property (!pin_oe_o[4] && $past(pin_oe_o[4]));
endmodule : gpio_mux_checker

// File: verification/companion_model.sv
// Companion and strap resistors on the low pins.
// Assumes pull-ups on pins 3 and 4, strap resistors on 1 and 2, and the companion reply on pin 0 while pin 3 is low.
`timescale 1ns/1ps
module companion_model (
    input wire logic [4:0] pin_o,
    input wire logic [4:0] pin_oe_o,
    input wire logic [1:0] strap_i,
    output logic [4:0] pin_i
);
    logic reply_ff = 1'b0;
    // Each received bit is answered inverted, so a stuck line shows.
    always @(posedge pin_i[1]) reply_ff <= ~pin_i[2];
    always_comb begin
        pin_i[4:3] = pin_oe_o[4:3] & pin_o[4:3] | ~pin_oe_o[4:3];
        pin_i[2:1] = pin_oe_o[2:1] & pin_o[2:1] | ~pin_oe_o[2:1] & strap_i;
        pin_i[0] = pin_oe_o[0] ? pin_o[0] : (pin_i[3] | reply_ff);
    end
endmodule : companion_model

// File: verification/low_gpio_function_mux_tb_top.sv
// Testbench for the low pin function multiplexer.
// Assumes the companion model resolves the pads; checker bound below.
`timescale 1ns/1ps
module low_gpio_function_mux_tb_top;
    logic clk = 1'b0, resetn = 1'b0, spi_clk = 1'b0, spi_do = 1'b0;
    logic sel_a_n = 1'b1, sel_b_n = 1'b1, left = 1'b0, spi_di, done;
    logic [9:0] io_mode = 10'h0, func_sel = 10'h0;
    logic [4:0] gpio_out = 5'h0, pin_i, pin_o, pin_oe, gpio_in;
    logic [1:0] strap = 2'h0;
    logic [2:0] lanes;
    int errors = 0, checks_done = 0, cycles = 0;
    always #25 clk = ~clk;
    low_gpio_function_mux dut (.ref_clk_i(clk), .resetn_i(resetn),
        .io_mode_i(io_mode), .func_sel_i(func_sel), .gpio_out_i(gpio_out),
        .aux_spi_clock_i(spi_clk), .aux_spi_data_out_i(spi_do),
        .aux_spi_select_a_n_i(sel_a_n), .aux_spi_select_b_n_i(sel_b_n),
        .shutter_left_i(left), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe_o(pin_oe), .gpio_in_o(gpio_in), .aux_spi_data_in_o(spi_di),
        .dsi_lane_count_o(lanes), .strap_done_o(done));
    companion_model far (.pin_o(pin_o), .pin_oe_o(pin_oe), .strap_i(strap),
        .pin_i(pin_i));
    task automatic check(input logic [4:0] seen, exp, input string m);
        checks_done++;
        if (seen !== exp) begin
            errors++;
            $display("[ERR] %0t %s seen %h expected %h", $time, m, seen, exp);
        end
    endtask : check
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask : step
    task automatic complete_run;
        $display("checks %0d mismatches %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : complete_run
    always @(posedge clk) begin
        cycles++;
        if (cycles == 3000) begin
            errors++;
            complete_run();
        end
    end
    task automatic test_boot(input logic [1:0] s);
        strap = s;
        resetn = 1'b0;
        step(8);
        resetn = 1'b1;
        step(2);
        check(done, 1'b0, "early strap");
        step(3);
        check(done, 1'b1, "strap missing");
        check(lanes, s + 3'h1, "lane count");
        strap = ~s;
        step(6);
        check(lanes, s + 3'h1, "lanes followed pins");
        $display("boot test %0d done", s);
    endtask : test_boot
    task automatic test_spi;
        io_mode = 10'h155;
        func_sel = 10'h155;
        sel_a_n = 1'b0;
        for (int i = 0; i < 4; i++) begin
            spi_do = i[0] ^ i[1];
            sel_b_n = ~spi_do;
            spi_clk = 1'b0;
            step(1);
            check(pin_o[4:1], {~spi_do, 1'b0, spi_do, 1'b0}, "spi out");
            check(pin_oe, 5'h1e, "spi enables");
            spi_clk = 1'b1;
            step(5);
            check(pin_o[1], 1'b1, "spi clock");
            check(spi_di, {~spi_do}, "spi in");
        end
        $display("spi test done");
    endtask : test_spi
    task automatic test_pin4;
        for (int l = 0; l < 2; l++) begin
            io_mode = 10'h155;
            func_sel = 10'h200;
            left = l[0];
            step(1);
            check(pin_o[4], l[0], "shutter");
            io_mode = 10'h355;
            func_sel = 10'h0;
            gpio_out[4] = l[0];
            step(1);
            check({pin_oe[4], pin_o[4]}, {~l[0], 1'b0}, "open drain");
        end
        $display("pin 4 test done");
    endtask : test_pin4
    task automatic test_gpio;
        io_mode = 10'h155;
        gpio_out = 5'h0a;
        step(1);
        check(pin_o, 5'h0a, "gpio out");
        check(pin_oe, 5'h1f, "gpio enables");
        gpio_out = 5'h0;
        step(1);
        check(pin_o, 5'h0, "unused low");
        io_mode = 10'h0;
        step(5);
        check(pin_oe, 5'h0, "inputs float");
        check(gpio_in, {2'b11, strap, 1'b1}, "gpio in");
        $display("gpio test done");
    endtask : test_gpio
    initial begin
        for (int s = 0; s < 4; s++) test_boot(s[1:0]);
        test_spi();
        test_pin4();
        test_gpio();
        complete_run();
    end
endmodule : low_gpio_function_mux_tb_top
bind low_gpio_function_mux gpio_mux_checker chk (.ref_clk_i(ref_clk_i),
    .resetn_i(resetn_i), .io_mode_i(io_mode_i), .func_sel_i(func_sel_i),
    .gpio_out_i(gpio_out_i), .aux_spi_clock_i(aux_spi_clock_i),
    .aux_spi_data_out_i(aux_spi_data_out_i),
    .aux_spi_select_a_n_i(aux_spi_select_a_n_i),
    .aux_spi_select_b_n_i(aux_spi_select_b_n_i),
    .shutter_left_i(shutter_left_i), .pin_i(pin_i), .pin_o(pin_o),
    .pin_oe_o(pin_oe_o), .aux_spi_data_in_o(aux_spi_data_in_o),
    .dsi_lane_count_o(dsi_lane_count_o), .strap_done_o(strap_done_o));
